// ### include/swt_pkg.sv
// Purpose: shared constants for the wake-up timer pair
// Assumes: 250 MHz main clock; 32 kHz sources arrive as pins and are sampled
// Notes: all timing counts derive from named rates

package swt_pkg;
  localparam int SWT_TIMER_W = 41;
  localparam int SWT_REF_W = 32;
  localparam int SWT_NUM_TIMERS = 2;
  localparam int SWT_CLK_HZ = 250000000;
  localparam int SWT_REF_HZ = 16000000;
  // divider for the 16 MHz reference tick, 250 MHz / 16 MHz rounded down
  localparam int SWT_REF_DIV = SWT_CLK_HZ / SWT_REF_HZ;
  localparam logic [SWT_TIMER_W-1:0] SWT_COUNT_RST = 41'h000_0000_0000;
  localparam logic [SWT_REF_W-1:0] SWT_REF_RST = 32'h0000_0000;
  localparam logic [1:0] SWT_FLAG_RST = 2'h0;

  typedef enum logic [2:0] {
    SWT_CAL_IDLE = 3'b001,
    SWT_CAL_RUN = 3'b010,
    SWT_CAL_DONE = 3'b100
  } swt_cal_state_t;
endpackage : swt_pkg

// ### verification/swt_props_properties.sv
// Purpose: port checks for the wake-up timer pair
// Assumes: one clock, sync reset
// Notes: timer 0 and the reference counter watched closely
`timescale 1ns/10ps
module swt_props #(parameter int TIMER_W = 41, parameter int REF_W = 32) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cal_start,
  input wire logic xtal_running,
  input wire logic status_read,
  input wire logic [1:0] irq_enable,
  input wire logic [1:0] load_strobe,
  input wire logic [1:0] stop_strobe,
  input wire logic [TIMER_W-1:0] load_value,
  input wire logic [TIMER_W-1:0] count0,
  input wire logic [1:0] running,
  input wire logic [1:0] expired,
  input wire logic irq,
  input wire logic [1:0] wake_event,
  input wire logic [REF_W-1:0] ref_count,
  input wire logic cal_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_irq_gated: assert property (irq == |(expired & irq_enable)) else $error("irq gate");
  a_load_taken: assert property (load_strobe[0] |=> count0 == $past(load_value)) else $error("load");
  a_stop_taken: assert property (stop_strobe[0] |=> !running[0]) else $error("stop");
  a_stopped_holds: assert property (!running[0] && !load_strobe[0] |=> $stable(count0)) else $error("hold");
  a_step_down: assert property (!$past(load_strobe[0]) && count0 != $past(count0)
    |-> count0 == $past(count0) - 1) else $error("step");
  a_expire_zero: assert property ($rose(expired[0]) |-> count0 == '0 && $past(running[0])) else $error("exp");
  a_status_clear: assert property (status_read |=> !expired[0] || count0 == '0) else $error("clear");
  a_wake_gated: assert property ((wake_event & ~$past(irq_enable)) == 2'h0) else $error("wake gate");
  a_wake_pulse: assert property (wake_event[1] |=> !wake_event[1]) else $error("wake len");
  a_cal_xtal: assert property (cal_start && !xtal_running && !cal_busy |=> !cal_busy) else $error("xtal");
  a_ref_holds: assert property (!cal_busy && !cal_start |=> $stable(ref_count)) else $error("ref");
endmodule : swt_props
bind swt_wakeup_timers swt_props #(.TIMER_W(TIMER_W), .REF_W(REF_W)) u_props (.clk(clk), .rst(rst),
  .cal_start(cal_start), .xtal_running(xtal_running), .status_read(status_read), .irq_enable(irq_enable),
  .load_strobe(load_strobe), .stop_strobe(stop_strobe), .load_value(load_value), .count0(count0),
  .running(running), .expired(expired), .irq(irq), .wake_event(wake_event), .ref_count(ref_count),
  .cal_busy(cal_busy));

// ### verification/tb.sv
// Purpose: directed bench for the wake-up timer pair
// Assumes: 32 kHz pins toggled by the bench, 11 clk per period
// Notes: short period keeps runs brief; ref count checked in a window
`timescale 1ns/10ps
module tb;
  import swt_pkg::*;
  logic clk = 0, rst = 1, rc = 0, ext = 0, sel = 0, slp = 0, dslp = 0, xtal = 0, cs = 0, sr = 0;
  logic [1:0] wk_seen = 0;
  logic [1:0] sdis = 0, ien = 0, ld = 0, st = 0, sp = 0, run, exf, wk;
  logic [40:0] lv = 0, c0, c1;
  logic [31:0] rcn;
  logic irq, busy;
  int error_cnt = 0, n_tests = 0;
  swt_wakeup_timers DUT (.clk(clk), .rst(rst), .rc_osc_32k(rc), .ext_clk_32k(ext), .src_sel_ext(sel),
    .sleep_mode(slp), .deep_sleep(dslp), .xtal_running(xtal), .sleep_disable(sdis), .irq_enable(ien),
    .load_strobe(ld), .load_value(lv), .start_strobe(st), .stop_strobe(sp), .cal_start(cs), .status_read(sr),
    .count0(c0), .count1(c1), .running(run), .expired(exf), .irq(irq), .wake_event(wk), .ref_count(rcn),
    .cal_busy(busy));
  initial forever #2 clk = ~clk;
  // wake is a one-cycle pulse; latch it so a later compare can see it
  always @(posedge clk) wk_seen <= wk_seen | wk;
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // pin high long enough to clear the synchroniser
  task tick(input bit e);
    @(posedge clk) if (e) ext <= 1; else rc <= 1;
    cyc(5);
    rc <= 0; ext <= 0;
    cyc(5);
  endtask : tick
  task pulse(input logic [1:0] l, s, p, input logic c, r);
    @(posedge clk) ld <= l; st <= s; sp <= p; cs <= c; sr <= r;
    @(posedge clk) ld <= 0; st <= 0; sp <= 0; cs <= 0; sr <= 0;
  endtask : pulse
  task chk(input logic [40:0] g, e);
    #1 n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
    // return on an edge so the next stimulus lands there by nba
    @(posedge clk);
  endtask : chk
  task end_sim;
    $display("errors %0d tests %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  initial begin
    cyc(6); rst <= 0; cyc(4);
    chk(c0, 0);
    pulse(0, 0, 0, 1, 0); cyc(1); chk(busy, 0);
    ien <= 1; lv <= 2; pulse(1, 1, 0, 0, 0);
    tick(0); chk(c0, 1);
    tick(0); chk(c0, 0); chk(exf, 1); chk(irq, 1);
    tick(0); chk(c0, 41'h1FFFFFFFFFF);
    pulse(0, 0, 1, 0, 0); tick(0); chk(c0, 41'h1FFFFFFFFFF); chk(run, 0);
    ien <= 0; cyc(1); chk(irq, 0); chk(exf, 1);
    pulse(0, 0, 0, 0, 1); cyc(1); chk(exf, 0);
    sel <= 1; slp <= 1; ien <= 2; pulse(2, 2, 0, 0, 0);
    cyc(1); chk(run, 2);
    tick(0); chk(c1, 2);
    tick(1); chk(c1, 1);
    dslp <= 1; cyc(4); tick(1); chk(c1, 1);
    dslp <= 0; cyc(4); tick(1); chk(c1, 0); chk(exf, 2);
    chk(wk_seen, 2); chk(irq, 1);
    sdis <= 2; tick(1); chk(c1, 0);
    slp <= 0; sdis <= 0; sel <= 0; xtal <= 1; lv <= 20;
    pulse(1, 0, 0, 1, 0); pulse(0, 1, 0, 0, 0); chk(busy, 1);
    repeat (21) tick(0);
    // window of 20 ticks of 11 clk, one reference count per divider period
    chk(rcn + 1 >= 20 * 11 / SWT_REF_DIV && rcn <= 20 * 11 / SWT_REF_DIV + 1, 1);
    chk(busy, 0);
    end_sim;
  end
endmodule : tb

// ### verilog/swt_wakeup_timers.sv
// Purpose: two 41-bit wake-up down counters with calibration reference counter
// Assumes: 32 kHz clocks and sleep levels come from outside and are synchronised here
// Notes: one clock domain; 32 kHz and 16 MHz rates are enable pulses

`timescale 1ns/10ps

module swt_wakeup_timers
  import swt_pkg::*;
#(
  parameter int TIMER_W = SWT_TIMER_W,
  parameter int REF_W = SWT_REF_W,
  parameter int REF_DIV = SWT_REF_DIV
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic rc_osc_32k,
  input wire logic ext_clk_32k,
  input wire logic src_sel_ext,
  input wire logic sleep_mode,
  input wire logic deep_sleep,
  input wire logic xtal_running,
  input wire logic [1:0] sleep_disable,
  input wire logic [1:0] irq_enable,
  input wire logic [1:0] load_strobe,
  input wire logic [TIMER_W-1:0] load_value,
  input wire logic [1:0] start_strobe,
  input wire logic [1:0] stop_strobe,
  input wire logic cal_start,
  input wire logic status_read,
  output logic [TIMER_W-1:0] count0,
  output logic [TIMER_W-1:0] count1,
  output logic [1:0] running,
  output logic [1:0] expired,
  output logic irq,
  output logic [1:0] wake_event,
  output logic [REF_W-1:0] ref_count,
  output logic cal_busy
);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [2:0] rc_sync_reg;
  logic [2:0] ext_sync_reg;
  logic [1:0] sleep_sync_reg;
  logic [1:0] deep_sync_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      rc_sync_reg <= 3'h0;
      ext_sync_reg <= 3'h0;
      sleep_sync_reg <= 2'h0;
      deep_sync_reg <= 2'h0;
    end else begin
      rc_sync_reg <= {rc_sync_reg[1:0], rc_osc_32k};
      ext_sync_reg <= {ext_sync_reg[1:0], ext_clk_32k};
      sleep_sync_reg <= {sleep_sync_reg[0], sleep_mode};
      deep_sync_reg <= {deep_sync_reg[0], deep_sleep};
    end
  end

  // edge detect reads only stages 1 and 2, never the first flop
  logic rc_tick;
  logic ext_tick;
  logic tick_32k;
  assign rc_tick = rc_sync_reg[1] & ~rc_sync_reg[2];
  assign ext_tick = ext_sync_reg[1] & ~ext_sync_reg[2];
  assign tick_32k = src_sel_ext ? ext_tick : rc_tick;

  // ------------------------------------------------------------
  // timer counters
  // ------------------------------------------------------------
  logic [TIMER_W-1:0] count_reg [2];
  logic [1:0] run_reg;
  logic [1:0] step;
  logic [1:0] zero_hit;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      // deep sleep always halts; plain sleep halts if disabled
      step[i] = run_reg[i] & tick_32k & ~deep_sync_reg[1]
                & ~(sleep_sync_reg[1] & sleep_disable[i]);
      zero_hit[i] = step[i] && (count_reg[i] == {{(TIMER_W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg[0] <= TIMER_W'(SWT_COUNT_RST);
      count_reg[1] <= TIMER_W'(SWT_COUNT_RST);
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (load_strobe[i]) begin
          count_reg[i] <= load_value;
        end else if (step[i]) begin
          count_reg[i] <= count_reg[i] - 1'b1; // wraps below zero
        end
      end
    end
  end

  // stop wins over start in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      run_reg <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (stop_strobe[i]) begin
          run_reg[i] <= 1'b0;
        end else if (start_strobe[i]) begin
          run_reg[i] <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // sticky expiry flags and wake/interrupt
  // ------------------------------------------------------------
  logic [1:0] expired_reg;
  logic [1:0] wake_reg;

  // a new expiry in the read cycle survives the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      expired_reg <= SWT_FLAG_RST;
    end else begin
      expired_reg <= (status_read ? 2'h0 : expired_reg) | zero_hit;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wake_reg <= 2'h0;
    end else begin
      wake_reg <= zero_hit & irq_enable & {2{sleep_sync_reg[1]}};
    end
  end

  assign irq = |(expired_reg & irq_enable);
  assign wake_event = wake_reg;
  assign expired = expired_reg;
  assign running = run_reg;
  assign count0 = count_reg[0];
  assign count1 = count_reg[1];

  // ------------------------------------------------------------
  // calibration reference counter
  // ------------------------------------------------------------
  localparam int DIV_W = $clog2(REF_DIV + 1);
  logic [DIV_W-1:0] div_reg;
  logic ref_tick;
  assign ref_tick = (div_reg == DIV_W'(REF_DIV - 1));

  // 16 MHz enable; 250/16 is not whole, so the rate runs slightly fast
  always_ff @(posedge clk) begin
    if (rst || ref_tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  swt_cal_state_t cal_state_reg;
  logic [REF_W-1:0] ref_reg;

  // zero_hit is already in this domain, so no crossing can drop it
  always_ff @(posedge clk) begin
    if (rst) begin
      cal_state_reg <= SWT_CAL_IDLE;
    end else begin
      unique case (cal_state_reg)
        SWT_CAL_IDLE: begin
          if (cal_start && xtal_running) begin
            cal_state_reg <= SWT_CAL_RUN;
          end
        end
        SWT_CAL_RUN: begin
          if (zero_hit[0]) begin
            cal_state_reg <= SWT_CAL_DONE;
          end
        end
        SWT_CAL_DONE: begin
          if (cal_start && xtal_running) begin
            cal_state_reg <= SWT_CAL_RUN;
          end
        end
        default: begin
          cal_state_reg <= SWT_CAL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_reg <= REF_W'(SWT_REF_RST);
    end else if (cal_start && xtal_running && cal_state_reg != SWT_CAL_RUN) begin
      ref_reg <= REF_W'(SWT_REF_RST);
    end else if (cal_state_reg == SWT_CAL_RUN && ref_tick && run_reg[0]) begin
      ref_reg <= ref_reg + 1'b1;
    end
  end

  assign ref_count = ref_reg;
  assign cal_busy = (cal_state_reg == SWT_CAL_RUN);

endmodule : swt_wakeup_timers
